// File: hw/pas_summer.sv
// Phased array summer: mixing, two adder stages, Hilbert combine, output split
// Function
// - Each antenna cable brings two sub-band streams with timing and sync.
// - Every antenna stream is complex mixed before any complex addition.
// - Antenna summation happens in two successive adder stages.
// - First stage sums fixed groups of four antennas.
// - Five independent second-stage adders each form one sub-array sum.
// - Hilbert transform filter combines the complex sums into the output.
// - Output is full width or split by on-board filters into narrower bands.
`timescale 1ns/100ps
`default_nettype none
module pas_summer
  import pas_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [SW-1:0]     ant_data [NUM_ANT][NUM_STR],
  input  wire logic              ant_valid,
  input  wire logic              ant_sync,
  output logic                   ant_ready,
  input  wire logic [PW-1:0]     phase_inc [NUM_ANT],
  input  wire logic [NUM_GRP-1:0] grp_map [NUM_SUB],
  input  wire logic              narrow_mode,
  output logic [FIFO_W-1:0]      out_data,
  output logic                   out_valid,
  input  wire logic              out_ready
);
  pas_stream_if fifo_in ();

  logic                  adv;
  logic [PIPE_LEN-1:0]   vld_r;
  logic [PIPE_LEN-1:0]   sync_r;
  pas_map_t              map_r;
  pas_mode_t             mode_r;
  logic                  dec_ph_r;
  logic signed [MW-1:0]  mix_i [NUM_ANT][NUM_STR];
  logic signed [MW-1:0]  mix_q [NUM_ANT][NUM_STR];
  logic signed [GW-1:0]  grp_i_r [NUM_GRP][NUM_STR];
  logic signed [GW-1:0]  grp_q_r [NUM_GRP][NUM_STR];
  logic signed [GW-1:0]  grp_i_nxt [NUM_GRP][NUM_STR];
  logic signed [GW-1:0]  grp_q_nxt [NUM_GRP][NUM_STR];
  logic signed [AW-1:0]  sub_i_r [NUM_SUB][NUM_STR];
  logic signed [AW-1:0]  sub_q_r [NUM_SUB][NUM_STR];
  logic signed [AW-1:0]  sub_i_nxt [NUM_SUB][NUM_STR];
  logic signed [AW-1:0]  sub_q_nxt [NUM_SUB][NUM_STR];
  logic signed [AW-1:0]  dl_i_r [NUM_SUB][NUM_STR][HT];
  logic signed [AW-1:0]  dl_q_r [NUM_SUB][NUM_STR][HT];
  logic signed [OW-1:0]  hil_r [NUM_SUB][NUM_STR];
  logic signed [OW-1:0]  prev_r [NUM_SUB][NUM_STR];
  logic [DATA_W-1:0]     word_nxt;
  logic                  wr_take;

  // Antisymmetric Hilbert FIR on Q, I taken from the centre tap
  function automatic logic signed [OW-1:0] pas_hilbert(
    input logic signed [AW-1:0] di [HT],
    input logic signed [AW-1:0] dq [HT]
  );
    logic signed [HW-1:0] acc;
    acc = (HW'(di[HT_MID]) <<< HT_SHIFT)
          - (HW'(dq[0]) - HW'(dq[6])) * HW'(2)
          - (HW'(dq[2]) - HW'(dq[4])) * HW'(5);
    pas_hilbert = OW'(acc >>> HT_SHIFT);
  endfunction

  // Whole pipeline moves one step per accepted input
  assign ant_ready = fifo_in.ready;
  assign adv       = ant_valid && fifo_in.ready;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vld_r  <= PIPE_RST;
      sync_r <= PIPE_RST;
    end else if (adv) begin
      vld_r  <= {vld_r[PIPE_LEN-2:0], 1'b1};
      sync_r <= {sync_r[PIPE_LEN-2:0], ant_sync};
    end
  end

  // Map and output mode taken only at a sync mark
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < NUM_SUB; s++) begin
        map_r[s] <= MAP_RST;
      end
      mode_r <= PAS_WIDE;
    end else if (adv && ant_sync) begin
      map_r  <= grp_map;
      mode_r <= narrow_mode ? PAS_NARROW : PAS_WIDE;
    end
  end

  generate
    for (genvar a = 0; a < NUM_ANT; a++) begin : g_mix
      pas_mixer u_mix (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .adv       (adv),
        .sync      (ant_sync),
        .sample    (ant_data[a]),
        .phase_inc (phase_inc[a]),
        .mix_i     (mix_i[a]),
        .mix_q     (mix_q[a])
      );
    end
  endgenerate

  // First stage: fixed groups of four
  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      for (int s = 0; s < NUM_STR; s++) begin
        grp_i_nxt[g][s] = '0;
        grp_q_nxt[g][s] = '0;
        for (int k = 0; k < GRP_SIZE; k++) begin
          grp_i_nxt[g][s] = grp_i_nxt[g][s] + GW'(mix_i[g*GRP_SIZE+k][s]);
          grp_q_nxt[g][s] = grp_q_nxt[g][s] + GW'(mix_q[g*GRP_SIZE+k][s]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        for (int s = 0; s < NUM_STR; s++) begin
          grp_i_r[g][s] <= '0;
          grp_q_r[g][s] <= '0;
        end
      end
    end else if (adv) begin
      grp_i_r <= grp_i_nxt;
      grp_q_r <= grp_q_nxt;
    end
  end

  // Second stage: one adder per sub-array over its member groups
  always_comb begin
    for (int u = 0; u < NUM_SUB; u++) begin
      for (int s = 0; s < NUM_STR; s++) begin
        sub_i_nxt[u][s] = '0;
        sub_q_nxt[u][s] = '0;
        for (int g = 0; g < NUM_GRP; g++) begin
          if (map_r[u][g]) begin
            sub_i_nxt[u][s] = sub_i_nxt[u][s] + AW'(grp_i_r[g][s]);
            sub_q_nxt[u][s] = sub_q_nxt[u][s] + AW'(grp_q_r[g][s]);
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < NUM_SUB; u++) begin
        for (int s = 0; s < NUM_STR; s++) begin
          sub_i_r[u][s] <= '0;
          sub_q_r[u][s] <= '0;
        end
      end
    end else if (adv) begin
      sub_i_r <= sub_i_nxt;
      sub_q_r <= sub_q_nxt;
    end
  end

  // Hilbert delay lines and combiner
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < NUM_SUB; u++) begin
        for (int s = 0; s < NUM_STR; s++) begin
          for (int t = 0; t < HT; t++) begin
            dl_i_r[u][s][t] <= '0;
            dl_q_r[u][s][t] <= '0;
          end
        end
      end
    end else if (adv) begin
      for (int u = 0; u < NUM_SUB; u++) begin
        for (int s = 0; s < NUM_STR; s++) begin
          dl_i_r[u][s][0] <= sub_i_r[u][s];
          dl_q_r[u][s][0] <= sub_q_r[u][s];
          for (int t = 1; t < HT; t++) begin
            dl_i_r[u][s][t] <= dl_i_r[u][s][t-1];
            dl_q_r[u][s][t] <= dl_q_r[u][s][t-1];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < NUM_SUB; u++) begin
        for (int s = 0; s < NUM_STR; s++) begin
          hil_r[u][s]  <= '0;
          prev_r[u][s] <= '0;
        end
      end
    end else if (adv) begin
      for (int u = 0; u < NUM_SUB; u++) begin
        for (int s = 0; s < NUM_STR; s++) begin
          hil_r[u][s]  <= pas_hilbert(dl_i_r[u][s], dl_q_r[u][s]);
          prev_r[u][s] <= hil_r[u][s];
        end
      end
    end
  end

  // Narrow mode: decimate by two into low and high half-bands
  // Sync word always kept, so the phase after it is the skip phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_ph_r <= 1'b0;
    end else if (adv && vld_r[PIPE_LEN-1]) begin
      dec_ph_r <= sync_r[PIPE_LEN-1] ? 1'b0 : !dec_ph_r;
    end
  end

  always_comb begin
    word_nxt = '0;
    for (int u = 0; u < NUM_SUB; u++) begin
      for (int s = 0; s < NUM_STR; s++) begin
        if (mode_r == PAS_NARROW) begin
          word_nxt[(u*NUM_STR+s)*OW +: OW] = {
            HALF_OW'(OW'((17'(hil_r[u][s]) + 17'(prev_r[u][s])) >>> 1) >> HALF_OW),
            HALF_OW'((17'(hil_r[u][s]) - 17'(prev_r[u][s])) >>> (HALF_OW + 1))};
        end else begin
          word_nxt[(u*NUM_STR+s)*OW +: OW] = hil_r[u][s];
        end
      end
    end
  end

  assign wr_take = vld_r[PIPE_LEN-1]
                   && (mode_r == PAS_WIDE || dec_ph_r || sync_r[PIPE_LEN-1]);
  assign fifo_in.valid = ant_valid && wr_take;
  assign fifo_in.data  = {sync_r[PIPE_LEN-1], mode_r == PAS_NARROW, word_nxt};

  pas_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .wr       (fifo_in),
    .rd_data  (out_data),
    .rd_valid (out_valid),
    .rd_ready (out_ready)
  );

  sequence s_sync_take;
    adv && ant_sync;
  endsequence

  sequence s_stall2;
    !adv [*2];
  endsequence

  sequence s_narrow_sync;
    adv && vld_r[PIPE_LEN-1] && sync_r[PIPE_LEN-1] && mode_r == PAS_NARROW;
  endsequence

  a_sync_carry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adv |=> vld_r[0] && sync_r[0] == $past(ant_sync))
    else $error("sync mark not carried with sample");

  a_map_sync_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(adv && ant_sync) |=> $stable(map_r[0]) && $stable(map_r[4]))
    else $error("membership map changed outside sync");

  a_map_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_sync_take |=> map_r[2] == $past(grp_map[2]))
    else $error("membership map not loaded at sync");

  a_mode_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_sync_take |=> mode_r == ($past(narrow_mode) ? PAS_NARROW : PAS_WIDE))
    else $error("output mode not loaded at sync");

  a_group_sum: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adv |=> grp_i_r[1][0] == GW'($past(mix_i[4][0])) + GW'($past(mix_i[5][0]))
                             + GW'($past(mix_i[6][0])) + GW'($past(mix_i[7][0])))
    else $error("group of four sum wrong");

  a_stall_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_stall2 |-> $stable(sub_i_r[3][1]) && $stable(grp_q_r[0][0]))
    else $error("adder stage moved without input");

  a_sub_empty: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adv && map_r[1] == '0 |=> sub_i_r[1][0] == 0 && sub_q_r[1][1] == 0)
    else $error("sub-array with no groups not zero");

  a_hilbert_flat: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adv && dl_q_r[0][0][0] == dl_q_r[0][0][6] && dl_q_r[0][0][2] == dl_q_r[0][0][4]
    |=> hil_r[0][0] == OW'($past(dl_i_r[0][0][3])))
    else $error("Hilbert combiner passes Q with flat input");

  a_narrow_rate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fifo_in.valid && mode_r == PAS_NARROW |-> dec_ph_r || sync_r[PIPE_LEN-1])
    else $error("narrow mode writes on wrong phase");

  a_narrow_sync: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_narrow_sync |-> fifo_in.valid)
    else $error("narrow mode drops sync word");
endmodule
`default_nettype wire

// File: hw/pas_pkg.sv
// Constants and types shared by the phased array summer
package pas_pkg;
  localparam int NUM_ANT  = 16;
  localparam int GRP_SIZE = 4;
  localparam int NUM_GRP  = NUM_ANT / GRP_SIZE;
  localparam int NUM_SUB  = 5;
  localparam int NUM_STR  = 2;
  localparam int SW       = 4;
  localparam int PW       = 16;
  localparam int LUT_BITS = 3;
  localparam int MW       = 12;
  localparam int GW       = 14;
  localparam int AW       = 16;
  localparam int HW       = 20;
  localparam int OW       = 16;
  localparam int HALF_OW  = OW / 2;
  localparam int HT       = 7;
  localparam int HT_MID   = 3;
  localparam int HT_SHIFT = 3;
  localparam int PIPE_LEN = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W   = NUM_SUB * NUM_STR * OW;
  localparam int FIFO_W   = DATA_W + 2;
  localparam int SYNC_POS = FIFO_W - 1;
  localparam int MODE_POS = FIFO_W - 2;
  localparam logic [PW-1:0] PHASE_RST = 16'h0000;
  localparam logic [PIPE_LEN-1:0] PIPE_RST = 5'h00;
  localparam logic [NUM_GRP-1:0] MAP_RST = 4'hf;

  typedef logic [NUM_GRP-1:0] pas_map_t [NUM_SUB];
  typedef enum logic [1:0] {
    PAS_WIDE   = 2'b00,
    PAS_NARROW = 2'b01
  } pas_mode_t;

  // Cosine table of the local oscillator, eight phase steps
  function automatic logic signed [7:0] pas_cos(input logic [LUT_BITS-1:0] idx);
    case (idx)
      3'h0:    pas_cos = 8'sh7f;
      3'h1:    pas_cos = 8'sh5a;
      3'h2:    pas_cos = 8'sh00;
      3'h3:    pas_cos = -8'sh5a;
      3'h4:    pas_cos = -8'sh7f;
      3'h5:    pas_cos = -8'sh5a;
      3'h6:    pas_cos = 8'sh00;
      default: pas_cos = 8'sh5a;
    endcase
  endfunction

  function automatic logic signed [7:0] pas_sin(input logic [LUT_BITS-1:0] idx);
    pas_sin = pas_cos(idx - 3'h2);
  endfunction
endpackage

// File: hw/pas_stream_if.sv
// Valid and ready stream between the summer datapath and its FIFO
`timescale 1ns/100ps
`default_nettype none
interface pas_stream_if;
  import pas_pkg::*;
  logic [FIFO_W-1:0] data;
  logic              valid;
  logic              ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// File: hw/pas_mixer.sv
// Complex mixer for the two streams of one antenna cable
`timescale 1ns/100ps
`default_nettype none
module pas_mixer
  import pas_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 adv,
  input  wire logic                 sync,
  input  wire logic [SW-1:0]        sample [NUM_STR],
  input  wire logic [PW-1:0]        phase_inc,
  output logic signed [MW-1:0]      mix_i [NUM_STR],
  output logic signed [MW-1:0]      mix_q [NUM_STR]
);
  logic [PW-1:0] phase_r;
  logic [PW-1:0] phase_use;
  logic [LUT_BITS-1:0] idx;

  // Oscillator restarts at every sync mark
  assign phase_use = sync ? PHASE_RST : phase_r;
  assign idx       = phase_use[PW-1 -: LUT_BITS];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= PHASE_RST;
    end else if (adv) begin
      phase_r <= phase_use + phase_inc;
    end
  end

  // Counter-rotation removes Doppler and offset shift
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < NUM_STR; s++) begin
        mix_i[s] <= '0;
        mix_q[s] <= '0;
      end
    end else if (adv) begin
      for (int s = 0; s < NUM_STR; s++) begin
        mix_i[s] <= MW'($signed(sample[s])) * MW'(pas_cos(idx));
        mix_q[s] <= -(MW'($signed(sample[s])) * MW'(pas_sin(idx)));
      end
    end
  end

  a_mix_zero_phase: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adv && sync |=> mix_q[0] == 0 && mix_i[0] == MW'($signed($past(sample[0]))) * MW'(8'sh7f))
    else $error("mixer not at zero phase after sync");
endmodule
`default_nettype wire

// File: hw/pas_fifo.sv
// Output FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module pas_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic    sys_clk,
  input  wire logic    rst_b,
  pas_stream_if.snk    wr,
  output logic [WIDTH-1:0] rd_data,
  output logic         rd_valid,
  input  wire logic    rd_ready
);
  localparam int AB = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AB-1:0]    wp_r;
  logic [AB-1:0]    rp_r;
  logic [AB:0]      cnt_r;
  logic             push;
  logic             pop;

  assign wr.ready = cnt_r < (AB+1)'(DEPTH);
  assign push     = wr.valid && wr.ready;
  assign pop      = (cnt_r != '0) && (!rd_valid || rd_ready);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= wr.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AB+1)'(push) - (AB+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else if (pop) begin
      rd_data  <= mem_r[rp_r];
      rd_valid <= 1'b1;
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end

  a_fifo_out_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("fifo output word not held until taken");
endmodule
`default_nettype wire

// File: verification/pas_src_model.sv
// Upstream station source model feeding every antenna cable of the summer
`timescale 1ns/100ps
`default_nettype none
module pas_src_model
  import pas_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          go,
  input  wire logic [7:0]    n_smp,
  input  wire logic          first_sync,
  input  wire logic          slow,
  input  wire logic [SW-1:0] grp_val [NUM_GRP][NUM_STR],
  input  wire logic          ant_ready,
  output logic [SW-1:0]      ant_data [NUM_ANT][NUM_STR],
  output logic               ant_valid,
  output logic               ant_sync,
  output logic               busy
);
  logic [7:0] left_r;
  logic       gap_r;
  logic [3:0] tick_r;

  assign busy = (left_r != 8'h00);

  // Sample, valid and sync held until taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_r    <= 8'h00;
      gap_r     <= 1'b0;
      ant_valid <= 1'b0;
      ant_sync  <= 1'b0;
    end else if (go && !busy) begin
      left_r    <= n_smp;
      ant_valid <= 1'b1;
      ant_sync  <= first_sync;
    end else if (ant_valid && ant_ready) begin
      left_r    <= left_r - 8'h01;
      ant_sync  <= 1'b0;
      ant_valid <= (left_r > 8'h01) && !slow;
      gap_r     <= slow;
    end else if (gap_r) begin
      gap_r     <= 1'b0;
      ant_valid <= busy;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_r <= 4'h0;
    end else begin
      tick_r <= tick_r + 4'h1;
    end
  end

  // Two streams per cable; idle lines show a moving pattern
  always_comb begin
    for (int a = 0; a < NUM_ANT; a++) begin
      for (int s = 0; s < NUM_STR; s++) begin
        ant_data[a][s] = ant_valid ? grp_val[a / GRP_SIZE][s] : (tick_r ^ 4'(a + s));
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_phased_array_summer.sv
// Self-checking bench of the phased array summer
`timescale 1ns/100ps
`default_nettype none
module tb_phased_array_summer;
  import pas_pkg::*;
  logic               sys_clk;
  logic               rst_b;
  logic               go;
  logic               first_sync;
  logic               slow;
  logic               narrow_mode;
  logic               out_ready;
  logic               ant_valid;
  logic               ant_sync;
  logic               ant_ready;
  logic               out_valid;
  logic               busy;
  logic               exp_nar;
  logic [7:0]         n_smp;
  logic [SW-1:0]      grp_val [NUM_GRP][NUM_STR];
  logic [SW-1:0]      ant_data [NUM_ANT][NUM_STR];
  logic [PW-1:0]      phase_inc [NUM_ANT];
  logic [NUM_GRP-1:0] grp_map [NUM_SUB];
  logic [NUM_GRP-1:0] exp_map [NUM_SUB];
  logic [FIFO_W-1:0]  out_data;
  logic [FIFO_W-1:0]  words [$];
  int                 failures;
  int                 checks;

  pas_summer u_pas_summer (.sys_clk(sys_clk), .rst_b(rst_b), .ant_data(ant_data),
    .ant_valid(ant_valid), .ant_sync(ant_sync), .ant_ready(ant_ready),
    .phase_inc(phase_inc), .grp_map(grp_map), .narrow_mode(narrow_mode),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));

  pas_src_model u_pas_src_model (.sys_clk(sys_clk), .rst_b(rst_b), .go(go), .n_smp(n_smp),
    .first_sync(first_sync), .slow(slow), .grp_val(grp_val), .ant_ready(ant_ready),
    .ant_data(ant_data), .ant_valid(ant_valid), .ant_sync(ant_sync), .busy(busy));

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      words.push_back(out_data);
    end
  end

  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wide slot is the mapped group sum at phase zero; narrow keeps the top byte
  function automatic logic [15:0] exp_slot(input int u, input int s);
    int acc;
    acc = 0;
    for (int g = 0; g < NUM_GRP; g++) begin
      if (exp_map[u][g]) begin
        acc += 4 * 127 * $signed(grp_val[g][s]);
      end
    end
    return exp_nar ? {acc[15:8], 8'h00} : acc[15:0];
  endfunction

  task automatic wait_idle();
    int k;
    int idle;
    k = 0;
    idle = 0;
    while (idle < 4) begin
      @(posedge sys_clk);
      idle = (busy === 1'b0 && out_valid === 1'b0) ? idle + 1 : 0;
      k++;
      if (k > 2000) begin
        failures++;
        final_report();
      end
    end
  endtask

  task automatic start_batch(input logic [7:0] n, input logic sy, input logic sl);
    @(posedge sys_clk);
    n_smp <= n;
    first_sync <= sy;
    slow <= sl;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask

  task automatic check_words(input int tail);
    int idx;
    int nsync;
    logic [FIFO_W-1:0] w;
    idx = 0;
    nsync = 0;
    foreach (words[i]) begin
      if (words[i][SYNC_POS] === 1'b1) begin
        idx = i;
        nsync++;
      end
    end
    w = (words.size() > 0) ? words[words.size() - 1] : '0;
    check(32'(nsync), (tail > 0) ? 32'h1 : 32'h0);
    if (tail > 0) begin
      check(32'(words.size() - idx), 32'(tail));
    end
    check({31'h0, w[MODE_POS]}, {31'h0, exp_nar});
    for (int u = 0; u < NUM_SUB; u++) begin
      for (int s = 0; s < NUM_STR; s++) begin
        check({16'h0, w[(u * NUM_STR + s) * OW +: OW]}, {16'h0, exp_slot(u, s)});
      end
    end
    words.delete();
  endtask

  task automatic test_wide();
    for (int a = 0; a < NUM_ANT; a++) begin
      phase_inc[a] <= 16'h2000;
    end
    start_batch(8'h08, 1'b0, 1'b0);
    wait_idle();
    words.delete();
    for (int a = 0; a < NUM_ANT; a++) begin
      phase_inc[a] <= 16'h0000;
    end
    start_batch(8'h10, 1'b1, 1'b0);
    wait_idle();
    check_words(11);
  endtask

  task automatic test_map();
    for (int g = 0; g < NUM_GRP; g++) begin
      grp_val[g][0] <= 4'(g + 1);
      grp_val[g][1] <= 4'(-(g + 1));
    end
    grp_map[0] <= 4'h1;
    grp_map[1] <= 4'h2;
    grp_map[2] <= 4'h4;
    grp_map[3] <= 4'h8;
    grp_map[4] <= 4'h5;
    exp_map = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5};
    start_batch(8'h10, 1'b1, 1'b1);
    wait_idle();
    check_words(11);
  endtask

  task automatic test_hold();
    for (int u = 0; u < NUM_SUB; u++) begin
      grp_map[u] <= 4'hf;
    end
    start_batch(8'h10, 1'b0, 1'b0);
    wait_idle();
    check_words(0);
  endtask

  task automatic test_narrow();
    narrow_mode <= 1'b1;
    exp_nar = 1'b1;
    exp_map = '{default: 4'hf};
    grp_map[1] <= 4'h0;
    exp_map[1] = 4'h0;
    start_batch(8'h10, 1'b1, 1'b0);
    wait_idle();
    check_words(6);
    narrow_mode <= 1'b0;
    exp_nar = 1'b0;
    start_batch(8'h10, 1'b1, 1'b0);
    wait_idle();
    check_words(11);
  endtask

  task automatic test_full();
    int k;
    out_ready <= 1'b0;
    start_batch(8'h18, 1'b1, 1'b0);
    k = 0;
    while (ant_ready !== 1'b0) begin
      @(posedge sys_clk);
      k++;
      if (k > 200) begin
        failures++;
        final_report();
      end
    end
    repeat (5) @(posedge sys_clk);
    check({31'h0, ant_ready}, 32'h0);
    check({31'h0, busy}, 32'h1);
    out_ready <= 1'b1;
    wait_idle();
    check(32'(words.size()), 32'd24);
    check_words(19);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    go = 1'b0;
    n_smp = 8'h00;
    first_sync = 1'b0;
    slow = 1'b0;
    narrow_mode = 1'b0;
    out_ready = 1'b1;
    exp_nar = 1'b0;
    failures = 0;
    checks = 0;
    phase_inc = '{default: 16'h0000};
    grp_map = '{default: 4'hf};
    exp_map = '{default: 4'hf};
    grp_val = '{default: '{4'h3, 4'he}};
    repeat (4) @(posedge sys_clk);
    check({31'h0, out_valid}, 32'h0);
    check({31'h0, ant_ready}, 32'h1);
    rst_b <= 1'b1;
    test_wide();
    test_map();
    test_hold();
    test_narrow();
    test_full();
    final_report();
  end
endmodule
`default_nettype wire
